// file: src/edr_params.svh
// Register offsets, field positions and counter limits of the error-log group.
// Assumes a 12-bit byte address from the controller's register area.
`ifndef EDR_PARAMS_SVH
`define EDR_PARAMS_SVH
`define EDR_OFF_IRQPEND  12'h214
`define EDR_OFF_IRQEN    12'h218
`define EDR_OFF_SCRLOG   12'h21C
`define EDR_OFF_LANE0    12'h220
`define EDR_OFF_LANE1    12'h224
`define EDR_OFF_LANE2    12'h228
`define EDR_OFF_LANECLR  12'h22C
`define EDR_OFF_ADDR1    12'h230
`define EDR_OFF_ROWHI    12'h234
`define EDR_OFF_ROWLO    12'h238
`define EDR_OFF_COL      12'h23C
`define EDR_OFF_LOC0     12'h240
`define EDR_OFF_PF0      12'h260
`define EDR_OFF_PF1      12'h264
`define EDR_OFF_PF2      12'h268
`define EDR_OFF_PF3      12'h26C
`define EDR_OFF_PFBANK   12'h270
`define EDR_BIT_UNCORRECTABLE_IRQ_ENABLE     4
`define EDR_BIT_CORRECTABLE_IRQ_ENABLE     0
`define EDR_BIT_SCRUB    31
`define EDR_BIT_RBACK    30
`define EDR_BIT_CLR      31
`define EDR_CNT_MAX      4'h7
`define EDR_CNT_MIN      4'h8
`endif

// file: src/edr_pkg.sv
// Types shared by the error-log register group.
// Assumes the params header is compiled alongside.
package edr_pkg;
    typedef struct packed {
        logic [2:0]  cs;
        logic [2:0]  bank;
        logic [15:0] row;
        logic [11:0] col;
    } edr_addr_s;
    typedef struct packed {
        logic       active;
        logic       draining;
        logic [4:0] fetchPos;
        logic [8:0] readPos;
        logic [15:0] row;
        logic [2:0] cs;
        logic [2:0] bankHigh;
    } edr_pf_s;
endpackage

// file: src/edr_error_log_regs.sv
// Error-statistics and status register group of the EDAC memory controller.
// Assumes a simple synchronous register port with one-cycle read answer.
//
// Overview of operation
// - One uncorrectable and one correctable irq enable, each for all ports.
// - Scrub uncorrectable flag bit 31 freezes location until cleared by write.
// - Readback mismatch flag bit 30 blocks further logging until cleared.
// - Log holds select, bank, row and column 11:4 while a flag is set.
// - Three lane registers: check bits, data high, data low.
// - Six-bit wrapping counter per byte lane at four fixed slots.
// - Writing 1 to bit 31 of lane register four clears counters, watermark.
// - Watermark tracks the smallest byte lane counter.
// - Writing 1 to bit 31 of address register one clears address counters.
// - Bank bit counters saturate, raised on bit one, lowered on zero.
// - Select bit counters exist only when enough selects are supported.
// - Row bit counters 15..8 and 7..0 in two registers, high nibble first.
// - Column bit counters 11 down to 4 in address register four.
// - Per port error addresses frozen while their pending bit is set.
// - Prefetch active at bit 31, draining at bit 30.
// - Prefetch fetch, read position and row fields exposed.
// - One prefetch status register per port plus one shared bank register.
// - Shared register holds per port select and high bank bits.
// - Port fields exist only for configured port counts; bank width varies.
// - Pending bits per port, write one to clear, mark location valid.
`include "edr_params.svh"
module edr_error_log_regs #(
    parameter int PORTS   = 4,
    parameter int NUM_CS  = 8
) (
    // Clock and control
    input  wire logic                  mclk,
    input  wire logic                  srst,
    input  wire logic                  clkEn,
    // Register port
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    input  wire logic [11:0]           regAddr,
    input  wire logic [31:0]           regWdata,
    output logic      [31:0]           regRdata,
    // Scrubber events
    input  wire logic                  scrubUe,
    input  wire logic                  readbackErr,
    input  wire edr_pkg::edr_addr_s    scrubAddr,
    input  wire logic                  scrubCe,
    input  wire logic [11:0]           scrubCeLanes,
    input  wire edr_pkg::edr_addr_s    ceAddr,
    // Access errors per port
    input  wire logic [3:0]            portCe,
    input  wire logic [3:0]            portUe,
    input  wire logic [4*32-1:0]       portErrAddr,
    // Prefetcher state per port
    input  wire edr_pkg::edr_pf_s [3:0] pfState,
    // Side-band error outputs
    output logic                       ceIrq,
    output logic                       ueIrq
);
    // Elaboration checks: the port and select decoding serve only these
    if (PORTS != 1 && PORTS != 2 && PORTS != 4) begin : g_bad_ports
        $error("PORTS must be 1, 2 or 4");
    end
    if (NUM_CS < 1 || NUM_CS > 8) begin : g_bad_cs
        $error("NUM_CS must be 1 to 8");
    end

    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0]  pend_q;
    logic        correctable_irq_enable_q, uncorrectable_irq_enable_q;
    logic        scrFlag_q, rbFlag_q;
    logic [33:0] log_q;
    logic [5:0]  lane_q [12];
    logic [5:0]  water_q;
    logic [3:0]  bankCnt_q [3];
    logic [3:0]  csCnt_q [3];
    logic [3:0]  rowCnt_q [16];
    logic [3:0]  colCnt_q [8];
    logic [31:0] loc_q [8];

    // Saturating signed step toward the address bit
    function automatic logic [3:0] satStep(input logic [3:0] c, input logic up);
        if (up)
            satStep = (c == `EDR_CNT_MAX) ? c : c + 4'h1;
        else
            satStep = (c == `EDR_CNT_MIN) ? c : c - 4'h1;
    endfunction

    // Address match only; strobes stay in the wires so they are re-evaluated
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    wire regWr    = regWrite && clkEn;
    wire wrPend   = regWr && hit(regAddr, `EDR_OFF_IRQPEND);
    wire wrEn     = regWr && hit(regAddr, `EDR_OFF_IRQEN);
    wire wrLog    = regWr && hit(regAddr, `EDR_OFF_SCRLOG);
    wire laneClr  = regWr && hit(regAddr, `EDR_OFF_LANECLR)
                    && regWdata[`EDR_BIT_CLR];
    wire addrClr  = regWr && hit(regAddr, `EDR_OFF_ADDR1)
                    && regWdata[`EDR_BIT_CLR];
    wire logFree  = !scrFlag_q && !rbFlag_q;
    // Ports that are not built never raise a pending bit
    localparam logic [3:0] PORTMASK = 4'((1 << PORTS) - 1);
    wire [7:0] pendSet = {portUe & PORTMASK, portCe & PORTMASK};

    // ************************************************************
    // Pending, enables, scrubber log
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            pend_q <= 8'h00;
            correctable_irq_enable_q <= 1'b0;
            uncorrectable_irq_enable_q <= 1'b0;
            scrFlag_q <= 1'b0;
            rbFlag_q <= 1'b0;
            log_q <= 34'h0;
        end else if (clkEn) begin
            // Set wins over a simultaneous clear
            pend_q <= (pend_q & ~(wrPend ? regWdata[7:0] : 8'h00)) | pendSet;
            if (wrEn) begin
                correctable_irq_enable_q <= regWdata[`EDR_BIT_CORRECTABLE_IRQ_ENABLE];
                uncorrectable_irq_enable_q <= regWdata[`EDR_BIT_UNCORRECTABLE_IRQ_ENABLE];
            end
            scrFlag_q <= (scrFlag_q && !(wrLog && regWdata[`EDR_BIT_SCRUB]))
                       || (logFree && scrubUe);
            rbFlag_q  <= (rbFlag_q && !(wrLog && regWdata[`EDR_BIT_RBACK]))
                       || (logFree && readbackErr && !scrubUe);
            if (logFree && (scrubUe || readbackErr))
                log_q <= scrubAddr;
        end
    end

    // ************************************************************
    // Location registers
    // ************************************************************
    genvar gp;
    generate
        for (gp = 0; gp < 8; gp++) begin : g_loc
            always_ff @(posedge mclk) begin
                if (srst)
                    loc_q[gp] <= 32'h0;
                else if (clkEn && pendSet[gp] && !pend_q[gp])
                    loc_q[gp] <= portErrAddr[(gp%4)*32 +: 32];
            end
        end
    endgenerate

    // ************************************************************
    // Byte lane counters and watermark
    // ************************************************************
    logic [5:0] minLane;
    always_comb begin
        minLane = lane_q[0];
        for (int i = 1; i < 12; i++)
            if (lane_q[i] < minLane)
                minLane = lane_q[i];
    end

    genvar gl;
    generate
        for (gl = 0; gl < 12; gl++) begin : g_lane
            always_ff @(posedge mclk) begin
                if (srst || (clkEn && laneClr))
                    lane_q[gl] <= 6'h00;
                else if (clkEn && scrubCe && scrubCeLanes[gl])
                    lane_q[gl] <= lane_q[gl] + 6'h01;
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (srst || (clkEn && laneClr))
            water_q <= 6'h00;
        else if (clkEn)
            water_q <= minLane;
    end

    // ************************************************************
    // Address bit counters
    // ************************************************************
    // Column bit 11 rides on address line 13 and bit 10 on line 11; the
    // scrubber hands over the logical column, so no remap here.
    genvar ga;
    generate
        for (ga = 0; ga < 3; ga++) begin : g_bc
            always_ff @(posedge mclk) begin
                if (srst || (clkEn && addrClr)) begin
                    bankCnt_q[ga] <= 4'h0;
                    csCnt_q[ga]   <= 4'h0;
                end else if (clkEn && scrubCe) begin
                    bankCnt_q[ga] <= satStep(bankCnt_q[ga], ceAddr.bank[ga]);
                    if (NUM_CS > (1 << ga))
                        csCnt_q[ga] <= satStep(csCnt_q[ga], ceAddr.cs[ga]);
                end
            end
        end
        for (ga = 0; ga < 16; ga++) begin : g_row
            always_ff @(posedge mclk) begin
                if (srst || (clkEn && addrClr))
                    rowCnt_q[ga] <= 4'h0;
                else if (clkEn && scrubCe)
                    rowCnt_q[ga] <= satStep(rowCnt_q[ga], ceAddr.row[ga]);
            end
        end
        for (ga = 0; ga < 8; ga++) begin : g_col
            always_ff @(posedge mclk) begin
                if (srst || (clkEn && addrClr))
                    colCnt_q[ga] <= 4'h0;
                else if (clkEn && scrubCe)
                    colCnt_q[ga] <= satStep(colCnt_q[ga], ceAddr.col[ga+4]);
            end
        end
    endgenerate

    // ************************************************************
    // Read multiplexer
    // ************************************************************
    function automatic logic [31:0] laneWord(input int r);
        laneWord = {2'b00, lane_q[4*r+3], 2'b00, lane_q[4*r+2],
                    2'b00, lane_q[4*r+1], 2'b00, lane_q[4*r]};
    endfunction

    function automatic logic [31:0] pfWord(input int p);
        pfWord = (p < PORTS) ? {pfState[p].active, pfState[p].draining,
                 pfState[p].fetchPos, pfState[p].readPos, pfState[p].row}
                 : 32'h0;
    endfunction

    // Bank high bits shrink as the port number supplies the low ones
    localparam logic [2:0] BANKMASK = (PORTS == 4) ? 3'b001 :
                                      (PORTS == 2) ? 3'b011 : 3'b111;
    function automatic logic [5:0] pfBank(input int p);
        pfBank = (p < PORTS) ? {pfState[p].cs, pfState[p].bankHigh & BANKMASK}
                 : 6'h00;
    endfunction

    wire [31:0] csWord = {4'h0, csCnt_q[2], csCnt_q[1], csCnt_q[0],
                          4'h0, bankCnt_q[2], bankCnt_q[1], bankCnt_q[0]};
    wire [31:0] logWord = (scrFlag_q || rbFlag_q) ?
        {scrFlag_q, rbFlag_q, log_q[33:12], log_q[11:4]} :
        {scrFlag_q, rbFlag_q, 30'h0};
    wire [31:0] rowHi = {rowCnt_q[15], rowCnt_q[14], rowCnt_q[13], rowCnt_q[12],
                         rowCnt_q[11], rowCnt_q[10], rowCnt_q[9], rowCnt_q[8]};
    wire [31:0] rowLo = {rowCnt_q[7], rowCnt_q[6], rowCnt_q[5], rowCnt_q[4],
                         rowCnt_q[3], rowCnt_q[2], rowCnt_q[1], rowCnt_q[0]};
    wire [31:0] colWord = {colCnt_q[7], colCnt_q[6], colCnt_q[5], colCnt_q[4],
                           colCnt_q[3], colCnt_q[2], colCnt_q[1], colCnt_q[0]};

    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0;
        case (regAddr)
            `EDR_OFF_IRQPEND: rdMux = {24'h0, pend_q};
            `EDR_OFF_IRQEN:   rdMux = {27'h0, uncorrectable_irq_enable_q, 3'h0, correctable_irq_enable_q};
            `EDR_OFF_SCRLOG:  rdMux = logWord;
            `EDR_OFF_LANE0:   rdMux = laneWord(2);
            `EDR_OFF_LANE1:   rdMux = laneWord(1);
            `EDR_OFF_LANE2:   rdMux = laneWord(0);
            `EDR_OFF_LANECLR: rdMux = {26'h0, water_q};
            `EDR_OFF_ADDR1:   rdMux = csWord;
            `EDR_OFF_ROWHI:   rdMux = rowHi;
            `EDR_OFF_ROWLO:   rdMux = rowLo;
            `EDR_OFF_COL:     rdMux = colWord;
            `EDR_OFF_PF0:     rdMux = pfWord(0);
            `EDR_OFF_PF1:     rdMux = pfWord(1);
            `EDR_OFF_PF2:     rdMux = pfWord(2);
            `EDR_OFF_PF3:     rdMux = pfWord(3);
            `EDR_OFF_PFBANK:  rdMux = {2'b00, pfBank(3), 2'b00, pfBank(2),
                                       2'b00, pfBank(1), 2'b00, pfBank(0)};
            default: begin
                if (regAddr >= `EDR_OFF_LOC0 && regAddr < `EDR_OFF_PF0)
                    rdMux = loc_q[regAddr[4:2]];
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            regRdata <= 32'h0;
            ceIrq <= 1'b0;
            ueIrq <= 1'b0;
        end else if (clkEn) begin
            regRdata <= regRead ? rdMux : 32'h0;
            ceIrq <= correctable_irq_enable_q && |(pendSet[3:0] & ~pend_q[3:0]);
            ueIrq <= uncorrectable_irq_enable_q && |(pendSet[7:4] & ~pend_q[7:4]);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_log_frozen: assert property (@(posedge mclk) disable iff (srst)
        (scrFlag_q || rbFlag_q) && !wrLog |=> $stable(log_q))
        else $error("log changed while flag set");
    a_rb_blocked: assert property (@(posedge mclk) disable iff (srst)
        rbFlag_q && !wrLog |=> rbFlag_q)
        else $error("readback flag dropped without clear");
    a_lane_clear: assert property (@(posedge mclk) disable iff (srst)
        laneClr |=> lane_q[0] == 6'h00 && water_q == 6'h00)
        else $error("lane clear failed");
    a_addr_clear: assert property (@(posedge mclk) disable iff (srst)
        addrClr |=> bankCnt_q[0] == 4'h0 && colCnt_q[7] == 4'h0)
        else $error("address clear failed");
    a_bank_sat: assert property (@(posedge mclk) disable iff (srst)
        bankCnt_q[0] == `EDR_CNT_MAX && scrubCe && ceAddr.bank[0] && clkEn
        && !addrClr |=> bankCnt_q[0] == `EDR_CNT_MAX)
        else $error("bank counter wrapped");
    a_loc_hold: assert property (@(posedge mclk) disable iff (srst)
        pend_q[1] |=> $stable(loc_q[1]))
        else $error("location overwritten while pending");
    a_pend_set: assert property (@(posedge mclk) disable iff (srst)
        pendSet[1] && clkEn |=> pend_q[1])
        else $error("pending not set");
    a_ue_gated: assert property (@(posedge mclk) disable iff (srst)
        !uncorrectable_irq_enable_q && clkEn |=> !ueIrq)
        else $error("uncorrectable irq while disabled");
    a_lane_wrap: assert property (@(posedge mclk) disable iff (srst)
        lane_q[0] == 6'h3F && scrubCe && scrubCeLanes[0] && clkEn
        && !laneClr |=> lane_q[0] == 6'h00)
        else $error("lane counter did not wrap");
endmodule // edr_error_log_regs

// file: test/tb_top.sv
// Self-checking bench for the error-log and status register group.
// Assumes the params header and package are compiled first; four ports.
`include "edr_params.svh"
`define TB_CHECK(gotVal, expVal) compare32(gotVal, expVal)
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic                       mclk = 1'b0;
    logic                       srst = 1'b1;
    logic                       clkEn = 1'b1;
    logic                       regWrite = 1'b0;
    logic                       regRead = 1'b0;
    logic [11:0]                regAddr = 12'h000;
    logic [31:0]                regWdata = 32'h0;
    logic [31:0]                regRdata;
    logic                       scrubUe = 1'b0;
    logic                       readbackErr = 1'b0;
    edr_pkg::edr_addr_s         scrubAddr = '0;
    logic                       scrubCe = 1'b0;
    logic [11:0]                scrubCeLanes = 12'h000;
    edr_pkg::edr_addr_s         ceAddr = '0;
    logic [3:0]                 portCe = 4'h0;
    logic [3:0]                 portUe = 4'h0;
    logic [127:0]               portErrAddr = '0;
    edr_pkg::edr_pf_s [3:0]     pfState = '0;
    logic                       ceIrq;
    logic                       ueIrq;
    int                         nErrors = 0;
    int                         samplesChecked = 0;
    int                         cycles = 0;
    int                         ceSeen = 0;
    int                         ueSeen = 0;

    edr_error_log_regs #(.PORTS(4), .NUM_CS(8)) dut_u (
        .mclk(mclk), .srst(srst), .clkEn(clkEn),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata),
        .scrubUe(scrubUe), .readbackErr(readbackErr),
        .scrubAddr(scrubAddr), .scrubCe(scrubCe),
        .scrubCeLanes(scrubCeLanes), .ceAddr(ceAddr),
        .portCe(portCe), .portUe(portUe), .portErrAddr(portErrAddr),
        .pfState(pfState), .ceIrq(ceIrq), .ueIrq(ueIrq)
    );

    always #5 mclk = ~mclk;
    // Counting pulses keeps the irq checks independent of exact latency;
    // the falling edge sees the pulses settled
    always @(negedge mclk) begin
        cycles++;
        if (ceIrq === 1'b1) ceSeen++;
        if (ueIrq === 1'b1) ueSeen++;
        if (cycles > 5000) begin
            nErrors++;
            finish_test();
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic compare32(input logic [31:0] g, input logic [31:0] e);
        samplesChecked++;
        if (g !== e) begin
            nErrors++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Every task starts one cycle after the last release, so no strobe
    // is lowered and raised again in the same time step
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk); #1;
        regWrite = 1'b1; regAddr = a; regWdata = d;
        @(posedge mclk); #1;
        regWrite = 1'b0;
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
        @(posedge mclk); #1;
        regRead = 1'b1; regAddr = a;
        @(posedge mclk); #1;
        regRead = 1'b0;
        `TB_CHECK(regRdata, e);
    endtask
    task automatic ev(input logic [3:0] ce, input logic [3:0] ue,
                      input logic sUe, input logic rb, input logic sCe);
        @(posedge mclk); #1;
        portCe = ce; portUe = ue; scrubUe = sUe; readbackErr = rb;
        scrubCe = sCe;
        @(posedge mclk); #1;
        portCe = 4'h0; portUe = 4'h0; scrubUe = 1'b0;
        readbackErr = 1'b0; scrubCe = 1'b0;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_reset_map;
        rdChk(`EDR_OFF_LANE0, 32'h0);
        rdChk(`EDR_OFF_LANECLR, 32'h0);
        rdChk(`EDR_OFF_IRQPEND, 32'h0);
        wr(12'h300, 32'hFFFF_FFFF);
        rdChk(12'h300, 32'h0);
    endtask
    task automatic test_clock_enable;
        clkEn = 1'b0;
        ev(4'h1, 4'h0, 1'b0, 1'b0, 1'b0);
        clkEn = 1'b1;
        rdChk(`EDR_OFF_IRQPEND, 32'h0);
    endtask
    task automatic test_scrub_log;
        scrubAddr = '{cs: 3'd5, bank: 3'd6, row: 16'hA5C3, col: 12'hBCD};
        ev(4'h0, 4'h0, 1'b1, 1'b0, 1'b0);
        rdChk(`EDR_OFF_SCRLOG, 32'hAEA5_C3BC);
        scrubAddr = '{cs: 3'd1, bank: 3'd2, row: 16'h0001, col: 12'h010};
        ev(4'h0, 4'h0, 1'b1, 1'b1, 1'b0);
        rdChk(`EDR_OFF_SCRLOG, 32'hAEA5_C3BC);
        wr(`EDR_OFF_SCRLOG, 32'h8000_0000);
        rdChk(`EDR_OFF_SCRLOG, 32'h0);
        ev(4'h0, 4'h0, 1'b0, 1'b1, 1'b0);
        rdChk(`EDR_OFF_SCRLOG, 32'h4A00_0101);
        scrubAddr = '{cs: 3'd7, bank: 3'd7, row: 16'hFFFF, col: 12'hFFF};
        ev(4'h0, 4'h0, 1'b0, 1'b1, 1'b0);
        rdChk(`EDR_OFF_SCRLOG, 32'h4A00_0101);
        wr(`EDR_OFF_SCRLOG, 32'h4000_0000);
        rdChk(`EDR_OFF_SCRLOG, 32'h0);
    endtask
    task automatic test_counters;
        wr(`EDR_OFF_ADDR1, 32'h8000_0000);
        rdChk(`EDR_OFF_COL, 32'h0);
        ceAddr = '{cs: 3'b110, bank: 3'b101, row: 16'h8001, col: 12'hC00};
        scrubCeLanes = 12'hFFF;
        repeat (9) ev(4'h0, 4'h0, 1'b0, 1'b0, 1'b1);
        rdChk(`EDR_OFF_ADDR1, 32'h0778_0787);
        rdChk(`EDR_OFF_ROWHI, 32'h7888_8888);
        rdChk(`EDR_OFF_ROWLO, 32'h8888_8887);
        rdChk(`EDR_OFF_COL, 32'h7788_8888);
        rdChk(`EDR_OFF_LANE0, 32'h0909_0909);
        rdChk(12'h224, 32'h0909_0909);
        rdChk(`EDR_OFF_LANECLR, 32'h9);
        scrubCeLanes = 12'h001;
        repeat (55) ev(4'h0, 4'h0, 1'b0, 1'b0, 1'b1);
        rdChk(12'h228, 32'h0909_0900);
        rdChk(`EDR_OFF_LANECLR, 32'h0);
        wr(`EDR_OFF_LANECLR, 32'h8000_0000);
        rdChk(12'h224, 32'h0);
        wr(`EDR_OFF_ADDR1, 32'h8000_0000);
        rdChk(`EDR_OFF_ROWLO, 32'h0);
    endtask
    task automatic test_port_errors;
        int ceBefore;
        int ueBefore;
        wr(`EDR_OFF_IRQEN, 32'hFFFF_FFFF);
        rdChk(`EDR_OFF_IRQEN, 32'h11);
        ceBefore = ceSeen;
        portErrAddr[63:32] = 32'h1234_5678;
        ev(4'h2, 4'h0, 1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge mclk);
        `TB_CHECK(ceSeen - ceBefore, 32'd1);
        rdChk(`EDR_OFF_IRQPEND, 32'h02);
        portErrAddr[63:32] = 32'hDEAD_BEEF;
        ev(4'h2, 4'h0, 1'b0, 1'b0, 1'b0);
        rdChk(12'h244, 32'h1234_5678);
        wr(`EDR_OFF_IRQPEND, 32'h02);
        rdChk(`EDR_OFF_IRQPEND, 32'h0);
        ev(4'h2, 4'h0, 1'b0, 1'b0, 1'b0);
        rdChk(12'h244, 32'hDEAD_BEEF);
        wr(`EDR_OFF_IRQEN, 32'h01);
        ueBefore = ueSeen;
        portErrAddr[95:64] = 32'hCAFE_0002;
        ev(4'h0, 4'h4, 1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge mclk);
        `TB_CHECK(ueSeen - ueBefore, 32'd0);
        rdChk(`EDR_OFF_IRQPEND, 32'h42);
        rdChk(12'h258, 32'hCAFE_0002);
        wr(`EDR_OFF_IRQPEND, 32'h42);
        wr(`EDR_OFF_IRQEN, 32'h10);
        ueBefore = ueSeen;
        ev(4'h0, 4'h8, 1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge mclk);
        `TB_CHECK(ueSeen - ueBefore, 32'd1);
        rdChk(`EDR_OFF_IRQPEND, 32'h80);
        wr(`EDR_OFF_IRQPEND, 32'h80);
    endtask
    task automatic test_prefetch;
        logic [31:0] bankExp;
        bankExp = 32'h0;
        for (int p = 0; p < 4; p++) begin
            pfState[p] = '{active: 1'b1, draining: p[0], fetchPos: 5'h15,
                readPos: 9'h1A3, row: 16'h4000 + 16'(p), cs: 3'(p + 1),
                bankHigh: 3'b111};
            bankExp |= {24'h0, 2'b00, 3'(p + 1), 3'b001} << (8 * p);
        end
        for (int p = 0; p < 4; p++)
            rdChk(12'(`EDR_OFF_PF0 + 4 * p), {1'b1, p[0], 5'h15, 9'h1A3,
                16'h4000 + 16'(p)});
        rdChk(`EDR_OFF_PFBANK, bankExp);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        #1 srst = 1'b0;
        test_reset_map();
        test_clock_enable();
        test_scrub_log();
        test_counters();
        test_port_errors();
        test_prefetch();
        finish_test();
    end
endmodule // tb_top
